// ===== inc/scbw_if.sv
// Purpose: two-wire management link between master and config decoder
// Assumes: open-drain pins, pull-ups modelled here
// Notes:   only the master drives the clock wire
`timescale 1ns/100ps
interface scbw_if;
  logic scl_m_o;
  logic scl_m_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;

  assign scl = scl_m_oe ? scl_m_o : 1'b1;
  assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);

  modport master (output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe,
                  input scl, sda);
  modport slave  (output sda_s_o, sda_s_oe, input scl, sda);
endinterface

// ===== inc/scbw_pkg.sv
// Purpose: shared constants and helpers of the config block write decoder
// Assumes: clk_sys at 250 MHz on both ends
// Notes:   bus bit time is set by the master's quarter-bit divider
package scbw_pkg;
  localparam logic [7:0] SCBW_CMD_WR   = 8'hBE;
  localparam logic [7:0] SCBW_BYTE_CNT = 8'h08;
  localparam logic [2:0] SCBW_OP_WR    = 3'h3;
  localparam logic [2:0] SCBW_OP_RD    = 3'h4;
  localparam logic [3:0] SCBW_ADDR_HI  = 4'hD;
  localparam logic [6:0] SCBW_ADDR_DEF = 7'h68;
  localparam int         SCBW_NPORT    = 6;
  // field positions inside the command bytes
  localparam int OP_MSB  = 2;
  localparam int PSH_MSB = 3;
  localparam int PSL_BIT = 7;
  localparam int BE_MSB  = 5;
  localparam int BE_LSB  = 2;
  localparam int AH_MSB  = 1;
  // byte positions inside a packet, address byte first
  localparam logic [3:0] IX_ADDR = 4'h0;
  localparam logic [3:0] IX_CMD  = 4'h1;
  localparam logic [3:0] IX_CNT  = 4'h2;
  localparam logic [3:0] IX_CB1  = 4'h3;
  localparam logic [3:0] IX_D1   = 4'h7;
  localparam logic [3:0] IX_PEC  = 4'hB;
  localparam logic [3:0] IX_OVER = 4'hC;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [1:0] Q_LAST  = 2'h3;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CRC_POLY = 8'h07;
  // bus timing: one quarter of a 1 MHz bit, keeps a packet short
  localparam int T_CLK_NS = 4;
  localparam int T_QTR_NS = 250;
  localparam int QTR_CYC  = (T_QTR_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam logic [9:0] QTR_CNT = 10'(QTR_CYC - 1);

  function automatic logic [7:0] scbw_crc8(input logic [7:0] crc,
                                           input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic [5:0] scbw_port_hit(input logic [4:0] p);
    logic [5:0] h;
    h = 6'h00;
    for (int i = 0; i < SCBW_NPORT; i++) begin
      if (p == 5'(i)) begin
        h[i] = 1'b1;
      end
    end
    return h;
  endfunction
endpackage

// ===== sim/scbw_properties.sv
// Purpose: wire checks of the master to slave config write link
// Assumes: link signals sampled on clk_sys
// Notes:   bit and byte counts are rebuilt from the wires
`timescale 1ns/100ps
module scbw_properties #(
  parameter logic [6:0] SLV_ADDR = 7'h68
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic scl_m_o,
  input wire logic scl_m_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  import scbw_pkg::*;
  logic       scl_q, sda_q, frame, next_frame, byte_end;
  logic [3:0] cnt, nbyte, next_cnt, next_nbyte;
  logic [7:0] sr, next_sr;

  assign byte_end = scl_q && !scl && cnt == 4'h8;

  always_comb begin
    next_frame = frame;
    next_cnt = cnt;
    next_nbyte = nbyte;
    next_sr = sr;
    if (scl_q && scl && sda_q && !sda) begin
      next_frame = 1'h1;
      next_cnt = 4'h0;
      next_nbyte = 4'h0;
    end else if (scl_q && scl && !sda_q && sda) begin
      next_frame = 1'h0;
    end else if (!scl_q && scl && frame) begin
      next_cnt = (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
      next_nbyte = (cnt == 4'h9) ? nbyte + 4'h1 : nbyte;
      if (cnt != 4'h8) begin
        next_sr = {sr[6:0], sda};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scl_q <= 1'h1;
      sda_q <= 1'h1;
      frame <= 1'h0;
      cnt   <= 4'h0;
      nbyte <= 4'h0;
      sr    <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      frame <= next_frame;
      cnt   <= next_cnt;
      nbyte <= next_nbyte;
      sr    <= next_sr;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  a_od_levels:
    assert property (!scl_m_o && !sda_m_o && !sda_s_o)
    else $error("open-drain value driven high");
  a_ack_edge_low:
    assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave data changed while clock high");
  a_ack_slot:
    assert property (sda_s_oe && scl && scl_q |-> cnt == 4'h9)
    else $error("slave drives data outside the ack bit");
  a_ack_stands:
    assert property ($rose(scl) && sda_s_oe |-> sda_s_oe [*8])
    else $error("ack dropped during clock high");
  a_idle_quiet:
    assert property (!frame |-> !sda_s_oe)
    else $error("slave drives data outside a frame");
  a_addr_ack:
    assert property (byte_end && nbyte == 4'h0 && sr == {SLV_ADDR, 1'h0}
                     |-> ##[1:8] sda_s_oe)
    else $error("own write address not acked");
  a_cmd_ack:
    assert property (byte_end && nbyte == 4'h1 && sr == SCBW_CMD_WR
                     |-> ##[1:8] sda_s_oe)
    else $error("write command code not acked");
  a_count_ack:
    assert property (byte_end && nbyte == 4'h2 && sr == SCBW_BYTE_CNT
                     |-> ##[1:8] sda_s_oe)
    else $error("byte count not acked");

  cover property (byte_end && nbyte == 4'hB);
  cover property ($fell(frame));
  cover property ($rose(sda_s_oe));
endmodule

// ===== sim/smbus_cfg_block_write_test.sv
// Purpose: self-checking bench of master and slave config write ends
// Assumes: second slave is driven by a bit-level bench driver
// Notes:   driver link clock period 32 ns, stretched low after acks
`timescale 1ns/100ps
module smbus_cfg_block_write_test;
  import scbw_pkg::*;
  logic        clk_sys, arst_n, go, use_pec, busy, done, nacked;
  logic        cv[2], pe[2], pec_dis[2];
  logic [2:0]  op, cop[2], strap[2];
  logic [3:0]  be, cbe[2];
  logic [4:0]  port, cpt[2];
  logic [5:0]  chit[2];
  logic [6:0]  dev_addr;
  logic [11:0] reg_addr, cad[2];
  logic [31:0] data, cdt[2];
  int          nv[2] = '{0, 0};
  int          ne[2] = '{0, 0};
  int          bad_count = 0;
  int          samples_checked = 0;

  scbw_if link[2] ();

  scbw_master scbw_master_inst (
    .clk_sys(clk_sys), .arst_n(arst_n), .link(link[0]), .go(go),
    .dev_addr(dev_addr), .op(op), .port(port), .be(be),
    .reg_addr(reg_addr), .data(data), .use_pec(use_pec),
    .busy(busy), .done(done), .nacked(nacked)
  );
  for (genvar g = 0; g < 2; g++) begin : gs
    scbw_slave scbw_slave_inst (
      .clk_sys(clk_sys), .arst_n(arst_n), .link(link[g]),
      .addr_strap(strap[g]), .pec_check_dis(pec_dis[g]),
      .cfg_valid(cv[g]), .cfg_op(cop[g]), .cfg_port(cpt[g]),
      .cfg_port_hit(chit[g]), .cfg_be(cbe[g]), .cfg_addr(cad[g]),
      .cfg_data(cdt[g]), .pkt_err(pe[g])
    );
    always @(posedge clk_sys) begin
      if (cv[g] === 1'h1) nv[g]++;
      if (pe[g] === 1'h1) ne[g]++;
    end
  end
  scbw_properties #(.SLV_ADDR(SCBW_ADDR_DEF)) scbw_properties_inst (
    .clk_sys(clk_sys), .arst_n(arst_n),
    .scl_m_o(link[0].scl_m_o), .scl_m_oe(link[0].scl_m_oe),
    .sda_m_o(link[0].sda_m_o), .sda_m_oe(link[0].sda_m_oe),
    .sda_s_o(link[0].sda_s_o), .sda_s_oe(link[0].sda_s_oe),
    .scl(link[0].scl), .sda(link[0].sda)
  );

  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic logic [7:0] crc8_ref(logic [7:0] c, logic [7:0] b);
    for (int k = 7; k >= 0; k--) begin
      c = {c[6:0], 1'h0} ^ ((c[7] ^ b[k]) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  // one ack bit per byte, first bad byte and all later ones refused
  function automatic logic [15:0] exp_acks(logic [7:0] pk[$], logic pd);
    logic [15:0] m;
    logic        ok;
    logic [7:0]  c;
    m = 16'h0000;
    ok = 1'h1;
    c = 8'h00;
    foreach (pk[i]) begin
      if (i == 0) ok = pk[0] == {SCBW_ADDR_HI, strap[1], 1'h0};
      if (i == 1) ok &= pk[1] == SCBW_CMD_WR;
      if (i == 2) ok &= pk[2] == SCBW_BYTE_CNT;
      if (i == 11) ok &= pd || pk[11] == c;
      if (i > 11) ok = 1'h0;
      if (i < 11) c = crc8_ref(c, pk[i]);
      m[i] = ok;
    end
    return m;
  endfunction

  task automatic chk_cfg(int g, logic [2:0] o, logic [4:0] p, logic [3:0] b,
                         logic [11:0] a, logic [31:0] d);
    check(32'(cop[g]), 32'(o));
    check(32'(cpt[g]), 32'(p));
    check(32'(chit[g]), (p < 5'h6) ? 32'h1 << p : 32'h0);
    check(32'(cbe[g]), 32'(b));
    check(32'(cad[g]), 32'({a[11:2], 2'h0}));
    check(cdt[g], d);
  endtask

  task automatic step(input logic scl_lo, input logic sda_lo, input int n);
    link[1].scl_m_oe <= scl_lo;
    link[1].sda_m_oe <= sda_lo;
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic bit_io(input logic b);
    step(1'h1, link[1].sda_m_oe, 2);
    step(1'h1, ~b, 2);
    step(1'h0, ~b, 4);
  endtask

  task automatic tx_byte(input logic [7:0] v, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(v[i]);
    bit_io(1'h1);
    ack = ~link[1].sda;
    step(1'h1, 1'h0, 4);
  endtask

  task automatic send_pkt(input logic [7:0] pk[$], input logic pd);
    logic [15:0] acks, m;
    logic        a, good;
    int          v0, e0, n;
    n = pk.size();
    v0 = nv[1];
    e0 = ne[1];
    acks = 16'h0000;
    pec_dis[1] <= pd;
    step(1'h0, 1'h1, 4);
    foreach (pk[i]) begin
      tx_byte(pk[i], a);
      acks[i] = a;
    end
    step(1'h1, 1'h1, 4);
    step(1'h0, 1'h1, 4);
    step(1'h0, 1'h0, 16);
    m = exp_acks(pk, pd);
    good = m[n - 1] && n >= 11 && n <= 12;
    check(32'(acks), 32'(m));
    check(nv[1] - v0, 32'(good));
    check(ne[1] - e0, 32'(m[0] && !good));
    if (good) begin
      chk_cfg(1, pk[3][2:0], {pk[4][3:0], pk[5][7]}, pk[5][5:2],
              {pk[5][1:0], pk[6], 2'h0}, {pk[7], pk[8], pk[9], pk[10]});
    end
  endtask

  initial begin
    logic [7:0]  pk[$];
    logic [31:0] cb, dt;
    logic [7:0]  c;
    int          kind, w;
    void'($urandom(20));
    arst_n = 1'h0;
    go = 1'h0;
    use_pec = 1'h1;
    dev_addr = SCBW_ADDR_DEF;
    op = SCBW_OP_WR;
    port = 5'($urandom_range(5, 0));
    be = 4'($urandom);
    reg_addr = 12'($urandom);
    data = $urandom;
    strap[0] = 3'h0;
    strap[1] = 3'($urandom_range(7, 1));
    pec_dis = '{1'h0, 1'h0};
    link[1].scl_m_o = 1'h0;
    link[1].sda_m_o = 1'h0;
    link[1].scl_m_oe = 1'h0;
    link[1].sda_m_oe = 1'h0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'h1;
    @(posedge clk_sys);
    check(cdt[1], 32'h0);
    for (int n = 0; n < 36; n++) begin
      kind = (n < 9) ? n : $urandom_range(8, 0);
      cb = (n == 0) ? 32'h0300BC3E : $urandom;
      dt = (n == 0) ? 32'h12345678 : $urandom;
      cb[26:24] = n[0] ? SCBW_OP_RD : SCBW_OP_WR;
      pk = '{{SCBW_ADDR_HI, strap[1], 1'h0}, SCBW_CMD_WR, SCBW_BYTE_CNT};
      c = 8'h00;
      for (int i = 3; i >= 0; i--) pk.push_back(cb[8 * i +: 8]);
      for (int i = 3; i >= 0; i--) pk.push_back(dt[8 * i +: 8]);
      foreach (pk[i]) c = crc8_ref(c, pk[i]);
      case (kind)
        1, 8: pk.push_back(c);
        4, 5: pk.push_back(~c);
        2: pk[1] ^= 8'($urandom_range(255, 1));
        3: pk[2] ^= 8'($urandom_range(255, 1));
        6: pk[0] ^= 8'h02;
        7: void'(pk.pop_back());
        default: ;
      endcase
      if (kind == 8) pk.push_back(8'h5A);
      send_pkt(pk, kind == 5);
    end
    go <= 1'h1;
    @(posedge clk_sys);
    go <= 1'h0;
    @(posedge clk_sys);
    check(32'(busy), 32'h1);
    for (w = 0; w < 40000 && done !== 1'h1; w++) @(posedge clk_sys);
    if (w == 40000) bad_count++;
    repeat (8) @(posedge clk_sys);
    check(32'(busy), 32'h0);
    check(32'(nacked), 32'h0);
    check(ne[0], 32'h0);
    check(nv[0], 32'h1);
    chk_cfg(0, op, port, be, reg_addr, data);
    complete_run();
  end
endmodule

// ===== verilog/scbw_master.sv
// Purpose: master end, sends one config register block write packet
// Assumes: go is a one-cycle pulse accepted only while idle
// Notes:   the bus clock is divided from clk_sys in quarter-bit steps
`timescale 1ns/100ps
module scbw_master (
  input  wire logic                    clk_sys,
  input  wire logic                    arst_n,
  scbw_if.master                       link,
  input  wire logic                    go,
  input  wire logic [6:0]              dev_addr,
  input  wire logic [2:0]              op,
  input  wire logic [4:0]              port,
  input  wire logic [3:0]              be,
  input  wire logic [11:0]             reg_addr,
  input  wire logic [31:0]             data,
  input  wire logic                    use_pec,
  output logic                         busy,
  output logic                         done,
  output logic                         nacked
);
  import scbw_pkg::*;

  typedef enum logic [1:0] {M_IDLE, M_START, M_BIT, M_STOP} scbw_mst_type;

  logic [1:0]   sda_sy;
  scbw_mst_type st;
  scbw_mst_type next_st;
  logic [9:0]   cnt;
  logic [9:0]   next_cnt;
  logic [1:0]   q;
  logic [1:0]   next_q;
  logic [3:0]   bitn;
  logic [3:0]   next_bitn;
  logic [3:0]   idx;
  logic [3:0]   next_idx;
  logic [7:0]   crc;
  logic [7:0]   next_crc;
  logic [7:0]   pkt [0:10];
  logic [7:0]   next_pkt [0:10];
  logic         pec_on;
  logic         next_pec_on;
  logic         scl_oe;
  logic         next_scl_oe;
  logic         sda_oe;
  logic         next_sda_oe;
  logic         next_done;
  logic         next_nacked;
  logic         tick;
  logic [7:0]   cur;
  logic [3:0]   last;

  always_comb begin
    tick        = cnt == QTR_CNT;
    cur         = (idx == IX_PEC) ? crc : pkt[idx];
    last        = pec_on ? IX_PEC : IX_PEC - 4'h1;
    next_st     = st;
    next_cnt    = tick ? 10'h000 : cnt + 10'h001;
    next_q      = tick ? q + 2'h1 : q;
    next_bitn   = bitn;
    next_idx    = idx;
    next_crc    = crc;
    next_pkt    = pkt;
    next_pec_on = pec_on;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_done   = 1'b0;
    next_nacked = nacked;
    case (st)
      M_IDLE: begin
        next_cnt = 10'h000;
        next_q   = 2'h0;
        if (go) begin
          next_pkt    = '{{dev_addr, 1'b0}, SCBW_CMD_WR, SCBW_BYTE_CNT,
                          {5'h00, op}, {4'h0, port[4:1]},
                          {port[0], 1'b0, be, reg_addr[11:10]},
                          reg_addr[9:2], data[31:24], data[23:16],
                          data[15:8], data[7:0]};
          next_pec_on = use_pec;
          next_idx    = IX_ADDR;
          next_bitn   = 4'h0;
          next_crc    = CRC_INIT;
          next_nacked = 1'b0;
          next_st     = M_START;
        end
      end
      M_START: begin
        if (tick && q == 2'h0) begin
          next_sda_oe = 1'b1;
        end
        if (tick && q == Q_LAST) begin
          next_scl_oe = 1'b1;
          next_st     = M_BIT;
        end
      end
      M_BIT: begin
        if (tick && q == 2'h0) begin
          next_sda_oe = (bitn == BIT_ACK) ? 1'b0 : ~cur[3'(7 - bitn)];
        end
        if (tick && q == 2'h1) begin
          next_scl_oe = 1'b0;
        end
        if (tick && q == Q_LAST) begin
          next_scl_oe = 1'b1;
          next_bitn   = bitn + 4'h1;
          if (bitn == BIT_ACK) begin
            next_bitn = 4'h0;
            next_crc  = scbw_crc8(crc, cur);
            next_idx  = idx + 4'h1;
            if (sda_sy[1] || idx == last) begin
              next_nacked = sda_sy[1];
              next_st     = M_STOP;
            end
          end
        end
      end
      M_STOP: begin
        if (tick && q == 2'h0) begin
          next_sda_oe = 1'b1;
        end
        if (tick && q == 2'h1) begin
          next_scl_oe = 1'b0;
        end
        if (tick && q == Q_LAST) begin
          next_sda_oe = 1'b0;
          next_done   = 1'b1;
          next_st     = M_IDLE;
        end
      end
      default: next_st = M_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sda_sy <= 2'h3;
      st     <= M_IDLE;
      cnt    <= 10'h000;
      q      <= 2'h0;
      bitn   <= 4'h0;
      idx    <= IX_ADDR;
      crc    <= CRC_INIT;
      pkt    <= '{default: 8'h00};
      pec_on <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      done   <= 1'b0;
      nacked <= 1'b0;
    end else begin
      sda_sy <= {sda_sy[0], link.sda};
      st     <= next_st;
      cnt    <= next_cnt;
      q      <= next_q;
      bitn   <= next_bitn;
      idx    <= next_idx;
      crc    <= next_crc;
      pkt    <= next_pkt;
      pec_on <= next_pec_on;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      done   <= next_done;
      nacked <= next_nacked;
    end
  end

  assign busy          = st != M_IDLE;
  assign link.scl_m_o  = 1'b0;
  assign link.scl_m_oe = scl_oe;
  assign link.sda_m_o  = 1'b0;
  assign link.sda_m_oe = sda_oe;
endmodule

// ===== verilog/scbw_slave.sv
// Purpose: slave end, decodes the config register block write packet
// Assumes: link pins arrive from outside clk_sys and are synchronised
// Notes:   the write is issued at the stop of a clean packet
// Behaviour
// - command code BEh means register block write
// - byte count must be 08h
// - command byte 1 bits 2:0 give operation
// - port select from byte2[3:0] and byte3[7]
// - access goes to port equal to select
// - byte3 bits 5:2 are byte write enables
// - address from byte3[1:0], byte4, low bits zero
// - data bytes arrive most significant first
// - optional trailing byte is error code
// - answer at slave address 68h to 6Fh, picked by the strap, write bit
// - nack first bad byte and all later
// - error code mismatch drops write, nacked
// - error check skipped while disable set
// - address low bits from three strap pins
`timescale 1ns/100ps
module scbw_slave (
  input  wire logic                    clk_sys,
  input  wire logic                    arst_n,
  scbw_if.slave                        link,
  input  wire logic [2:0]              addr_strap,
  input  wire logic                    pec_check_dis,
  output logic                         cfg_valid,
  output logic [2:0]                   cfg_op,
  output logic [4:0]                   cfg_port,
  output logic [5:0]                   cfg_port_hit,
  output logic [3:0]                   cfg_be,
  output logic [11:0]                  cfg_addr,
  output logic [31:0]                  cfg_data,
  output logic                         pkt_err
);
  import scbw_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_RECV, S_ACK, S_SKIP} scbw_st_type;

  // input synchronisers and strap capture
  logic [1:0] scl_sy;
  logic [1:0] sda_sy;
  logic       scl_q;
  logic       sda_q;
  logic [2:0] strap_s1;
  logic [2:0] strap_s2;
  logic [6:0] dev_addr;
  logic       strap_v1;
  logic       strap_v2;
  logic       strap_done;
  logic [6:0] next_dev_addr;

  // load the strap only once the synchroniser holds a real sample
  always_comb begin
    next_dev_addr = dev_addr;
    if (strap_v2 && !strap_done) begin
      next_dev_addr = {SCBW_ADDR_HI, strap_s2};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      scl_sy     <= 2'h3;
      sda_sy     <= 2'h3;
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      strap_s1   <= 3'h0;
      strap_s2   <= 3'h0;
      dev_addr   <= SCBW_ADDR_DEF;
      strap_v1   <= 1'b0;
      strap_v2   <= 1'b0;
      strap_done <= 1'b0;
    end else begin
      scl_sy     <= {scl_sy[0], link.scl};
      sda_sy     <= {sda_sy[0], link.sda};
      scl_q      <= scl_sy[1];
      sda_q      <= sda_sy[1];
      strap_s1   <= addr_strap;
      strap_s2   <= strap_s1;
      dev_addr   <= next_dev_addr;
      strap_v1   <= 1'b1;
      strap_v2   <= strap_v1;
      strap_done <= strap_v2;
    end
  end

  // bus events, seen on the second stage only
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  always_comb begin
    scl_rise = scl_sy[1] & ~scl_q;
    scl_fall = ~scl_sy[1] & scl_q;
    start_ev = scl_sy[1] & scl_q & sda_q & ~sda_sy[1];
    stop_ev  = scl_sy[1] & scl_q & ~sda_q & sda_sy[1];
  end

  // packet state
  scbw_st_type st;
  scbw_st_type next_st;
  logic [3:0]  bitn;
  logic [3:0]  next_bitn;
  logic [7:0]  shreg;
  logic [7:0]  next_shreg;
  logic [3:0]  idx;
  logic [3:0]  next_idx;
  logic        bad;
  logic        next_bad;
  logic [7:0]  crc;
  logic [7:0]  next_crc;
  logic        ack_oe;
  logic        next_ack_oe;
  logic [7:0]  pkt [0:7];
  logic [7:0]  next_pkt [0:7];
  logic        next_cfg_valid;
  logic        next_pkt_err;
  logic [2:0]  next_cfg_op;
  logic [4:0]  next_cfg_port;
  logic [3:0]  next_cfg_be;
  logic [11:0] next_cfg_addr;
  logic [31:0] next_cfg_data;
  logic [5:0]  next_cfg_port_hit;
  logic        byte_ok;
  logic        commit;

  always_comb begin
    next_st        = st;
    next_bitn      = bitn;
    next_shreg     = shreg;
    next_idx       = idx;
    next_bad       = bad;
    next_crc       = crc;
    next_ack_oe    = ack_oe;
    next_pkt       = pkt;
    next_cfg_valid = 1'b0;
    next_pkt_err   = 1'b0;
    next_cfg_op    = cfg_op;
    next_cfg_port  = cfg_port;
    next_cfg_be    = cfg_be;
    next_cfg_addr  = cfg_addr;
    next_cfg_data  = cfg_data;
    next_cfg_port_hit = cfg_port_hit;
    byte_ok        = 1'b1;
    commit         = 1'b0;
    if (start_ev) begin
      next_st     = S_RECV;
      next_bitn   = 4'h0;
      next_idx    = IX_ADDR;
      next_bad    = 1'b0;
      next_crc    = CRC_INIT;
      next_ack_oe = 1'b0;
    end else if (stop_ev) begin
      next_st     = S_IDLE;
      next_ack_oe = 1'b0;
      if (st != S_IDLE && st != S_SKIP) begin
        commit = ~bad & (idx == IX_PEC || idx == IX_OVER);
        next_pkt_err = ~commit & (idx != IX_ADDR);
      end
    end else begin
      case (st)
        S_RECV: begin
          if (scl_rise && bitn != BIT_ACK) begin
            next_shreg = {shreg[6:0], sda_sy[1]};
            next_bitn  = bitn + 4'h1;
          end else if (scl_fall && bitn == BIT_ACK) begin
            next_bitn = 4'h0;
            case (idx)
              IX_ADDR: byte_ok = shreg[7:1] == dev_addr && !shreg[0];
              IX_CMD:  byte_ok = shreg == SCBW_CMD_WR;
              IX_CNT:  byte_ok = shreg == SCBW_BYTE_CNT;
              IX_PEC:  byte_ok = pec_check_dis || shreg == crc;
              IX_OVER: byte_ok = 1'b0;
              default: byte_ok = 1'b1;
            endcase
            if (idx >= IX_CB1 && idx < IX_PEC) begin
              next_pkt[3'(idx - IX_CB1)] = shreg;
            end
            if (idx < IX_PEC) begin
              next_crc = scbw_crc8(crc, shreg);
            end
            if (idx != IX_OVER) begin
              next_idx = idx + 4'h1;
            end
            if (idx == IX_ADDR && !byte_ok) begin
              next_st = S_SKIP;
            end else begin
              next_bad    = bad | ~byte_ok;
              next_ack_oe = bad ? 1'b0 : byte_ok;
              next_st     = S_ACK;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            next_ack_oe = 1'b0;
            next_st     = S_RECV;
          end
        end
        S_SKIP:  next_st = S_SKIP;
        default: next_st = S_IDLE;
      endcase
    end
    if (commit) begin
      next_cfg_valid = 1'b1;
      next_cfg_op    = pkt[0][OP_MSB:0];
      next_cfg_port  = {pkt[1][PSH_MSB:0], pkt[2][PSL_BIT]};
      next_cfg_port_hit = scbw_port_hit(next_cfg_port);
      next_cfg_be    = pkt[2][BE_MSB:BE_LSB];
      next_cfg_addr  = {pkt[2][AH_MSB:0], pkt[3], 2'h0};
      next_cfg_data  = {pkt[4], pkt[5], pkt[6], pkt[7]};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st        <= S_IDLE;
      bitn      <= 4'h0;
      shreg     <= 8'h00;
      idx       <= IX_ADDR;
      bad       <= 1'b0;
      crc       <= CRC_INIT;
      ack_oe    <= 1'b0;
      pkt       <= '{default: 8'h00};
      cfg_valid <= 1'b0;
      pkt_err   <= 1'b0;
      cfg_op    <= 3'h0;
      cfg_port  <= 5'h00;
      cfg_be    <= 4'h0;
      cfg_addr  <= 12'h000;
      cfg_data  <= 32'h0000_0000;
      cfg_port_hit <= 6'h00;
    end else begin
      st        <= next_st;
      bitn      <= next_bitn;
      shreg     <= next_shreg;
      idx       <= next_idx;
      bad       <= next_bad;
      crc       <= next_crc;
      ack_oe    <= next_ack_oe;
      pkt       <= next_pkt;
      cfg_valid <= next_cfg_valid;
      pkt_err   <= next_pkt_err;
      cfg_op    <= next_cfg_op;
      cfg_port  <= next_cfg_port;
      cfg_be    <= next_cfg_be;
      cfg_addr  <= next_cfg_addr;
      cfg_data  <= next_cfg_data;
      cfg_port_hit <= next_cfg_port_hit;
    end
  end

  assign link.sda_s_o  = 1'b0;
  assign link.sda_s_oe = ack_oe;
endmodule
